//--- rtl/uptp_pkg.sv
// shared constants and carrier types for the port owner/power/line-state block
package uptp_pkg;
  // test-control encodings
  localparam logic [3:0] UPTP_TEST_NONE = 4'h0;
  localparam logic [3:0] UPTP_TEST_J = 4'h1;
  localparam logic [3:0] UPTP_TEST_K = 4'h2;
  localparam logic [3:0] UPTP_TEST_SE0_NAK = 4'h3;
  localparam logic [3:0] UPTP_TEST_PACKET = 4'h4;
  localparam logic [3:0] UPTP_TEST_FORCE_EN = 4'h5;
  // line-state codes, bit 1 = positive line, bit 0 = negative line
  localparam logic [1:0] UPTP_LS_SE0 = 2'h0;
  localparam logic [1:0] UPTP_LS_K = 2'h1;
  localparam logic [1:0] UPTP_LS_J = 2'h2;
  // field positions inside the port status word
  localparam int UPTP_POS_TEST = 16;
  localparam int UPTP_POS_OWNER = 13;
  localparam int UPTP_POS_POWER = 12;
  localparam int UPTP_POS_LS = 10;
  // values after reset
  localparam logic UPTP_RST_OWNER = 1'b1;
  localparam logic UPTP_RST_POWER = 1'b0;
  localparam logic [3:0] UPTP_RST_TEST = 4'h0;

  // decoded test-mode drive towards the transceiver
  typedef struct packed {
    logic j_state;
    logic k_state;
    logic se0_nak;
    logic packet;
    logic force_en;
  } uptp_test_t;

  // software write strobes with data
  typedef struct packed {
    logic test_we;
    logic [3:0] test_data;
    logic owner_we;
    logic owner_data;
    logic power_we;
    logic power_data;
  } uptp_wr_t;
endpackage

//--- rtl/uptp_port.sv
// port test select, companion ownership, port power and line-state sampling
`timescale 1ns/1ps
// Functional notes
// - test codes 2..5 drive K, SE0_NAK, packet, force-enable
// - code 0 is normal, code 1 is J
// - ownership clears on configure flag rising
// - ownership forced 1 while flag 0; resets 1
// - ownership 1 hands port to companion
// - no switch capability: power reads 1, always on; reset still loads 0, and the bit reads 1 from the first edge after reset
// - with capability, power bit drives the switch
// - unpowered port reports no status changes
// - overcurrent on powered switched port clears power
// - line-state bit 11 positive, bit 10 negative
// - line state undefined while unpowered
module uptp_port
  import uptp_pkg::*;
#(
  parameter int TEST_W = 4
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // software write side
  input wire uptp_wr_t WR,
  // system inputs
  input wire logic CONFIGURE_FLAG,
  input wire logic POWER_SWITCH_CAP,
  input wire logic OVERCURRENT,
  input wire logic PORT_ENABLED,
  input wire logic CONNECT_STATUS,
  input wire logic STATUS_CHANGE_IN,
  // data line pins, asynchronous
  input wire logic POSITIVE_DATA_LINE,
  input wire logic NEGATIVE_DATA_LINE,
  // readback fields
  output logic [TEST_W-1:0] PORT_TEST_SELECT,
  output logic COMPANION_OWNERSHIP_BIT,
  output logic PORT_POWER_BIT,
  output logic [1:0] LINE_STATE_FIELD,
  // port control outputs
  output uptp_test_t TEST_DRIVE,
  output logic COMPANION_OWNS,
  output logic POWER_SWITCH_ON,
  output logic STATUS_CHANGE_OUT,
  output logic LS_VALID
);

  // software fields and flag history
  logic [TEST_W-1:0] test_r, test_nxt;
  logic owner_r, owner_nxt;
  logic power_r, power_nxt;
  logic cf_prev_r, cf_prev_nxt;
  // pin synchronisers and sampled line state
  logic [1:0] ls_meta_r, ls_sync_r, ls_r, ls_nxt;
  logic oc_meta_r, oc_sync_r;
  // registered copies that feed the outputs
  uptp_test_t drive_r, drive_nxt;
  logic own_out_r, own_out_nxt;
  logic sw_r, sw_nxt;
  logic chg_r, chg_nxt;
  logic lsv_r, lsv_nxt;
  logic cf_rise;

  // flag rise against last cycle; the flag idles low, so reset makes no false edge
  assign cf_rise = CONFIGURE_FLAG & ~cf_prev_r;

  // next-state logic for the control fields
  always_comb begin
    test_nxt = test_r;
    if (WR.test_we) begin
      test_nxt = TEST_W'(WR.test_data);
    end
    cf_prev_nxt = CONFIGURE_FLAG;
    // ownership: software write first, hardware overrides after
    owner_nxt = owner_r;
    if (WR.owner_we) begin
      owner_nxt = WR.owner_data;
    end
    // hardware overrides beat the software write
    if (!CONFIGURE_FLAG) begin
      owner_nxt = 1'b1;
    end else if (cf_rise) begin
      owner_nxt = 1'b0;
    end
    // power: fixed on without switches, else the software bit
    power_nxt = power_r;
    if (!POWER_SWITCH_CAP) begin
      power_nxt = 1'b1;
    end else begin
      if (WR.power_we) begin
        power_nxt = WR.power_data;
      end
      // overcurrent wins so a fault never gets re-powered the same cycle
      if (oc_sync_r && power_r) begin
        power_nxt = 1'b0;
      end
    end
  end

  // line state, test decode and port drive outputs
  always_comb begin
    // unpowered port shows SE0, not stale pins; any value is legal there
    ls_nxt = ls_sync_r;
    if (!power_r) begin
      ls_nxt = UPTP_LS_SE0;
    end
    // one-hot test decode; reserved codes land in default
    drive_nxt = '0;
    unique case (test_r)
      UPTP_TEST_J: drive_nxt.j_state = 1'b1;
      UPTP_TEST_K: drive_nxt.k_state = 1'b1;
      UPTP_TEST_SE0_NAK: drive_nxt.se0_nak = 1'b1;
      UPTP_TEST_PACKET: drive_nxt.packet = 1'b1;
      UPTP_TEST_FORCE_EN: drive_nxt.force_en = 1'b1;
      default: drive_nxt = '0; // code 0 and reserved codes drive nothing
    endcase
    // derived controls lag their field by a cycle so outputs stay flop-driven
    own_out_nxt = owner_r;
    sw_nxt = power_r;
    chg_nxt = STATUS_CHANGE_IN & power_r;
    lsv_nxt = power_r & ~PORT_ENABLED & CONNECT_STATUS; // helps software
  end

  // registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      test_r <= TEST_W'(UPTP_RST_TEST);
      owner_r <= UPTP_RST_OWNER;
      power_r <= UPTP_RST_POWER;
      cf_prev_r <= 1'b0;
      ls_meta_r <= 2'h0;
      ls_sync_r <= 2'h0;
      ls_r <= 2'h0;
      oc_meta_r <= 1'b0;
      oc_sync_r <= 1'b0;
      drive_r <= '0;
      own_out_r <= 1'b1;
      sw_r <= 1'b0;
      chg_r <= 1'b0;
      lsv_r <= 1'b0;
    end else begin
      // fields and flag history
      test_r <= test_nxt;
      owner_r <= owner_nxt;
      power_r <= power_nxt;
      cf_prev_r <= cf_prev_nxt;
      // pins cross in through two flops
      ls_meta_r <= {POSITIVE_DATA_LINE, NEGATIVE_DATA_LINE};
      ls_sync_r <= ls_meta_r;
      ls_r <= ls_nxt;
      // overcurrent crosses the same way, so the cut lands two cycles late
      oc_meta_r <= OVERCURRENT;
      oc_sync_r <= oc_meta_r;
      drive_r <= drive_nxt;
      own_out_r <= own_out_nxt;
      sw_r <= sw_nxt;
      chg_r <= chg_nxt;
      lsv_r <= lsv_nxt;
    end
  end

  // outputs straight from flops
  assign PORT_TEST_SELECT = test_r;
  assign COMPANION_OWNERSHIP_BIT = owner_r;
  assign PORT_POWER_BIT = power_r;
  assign LINE_STATE_FIELD = ls_r;
  assign TEST_DRIVE = drive_r;
  assign COMPANION_OWNS = own_out_r;
  assign POWER_SWITCH_ON = sw_r;
  assign STATUS_CHANGE_OUT = chg_r;
  assign LS_VALID = lsv_r;

  // checks: test-mode decode and the software-held select
  a_test_decode: assert property (@(posedge CLK) disable iff (!RST_N)
    (test_r == UPTP_TEST_K) |=> TEST_DRIVE.k_state && !TEST_DRIVE.j_state)
    else $error("K test mode not driven");

  a_test_none: assert property (@(posedge CLK) disable iff (!RST_N)
    (test_r == UPTP_TEST_NONE) |=> TEST_DRIVE == '0)
    else $error("drive in normal mode");

  a_test_jstate: assert property (@(posedge CLK) disable iff (!RST_N)
    (test_r == UPTP_TEST_J) |=> TEST_DRIVE.j_state)
    else $error("J test mode not driven");

  a_test_se0nak: assert property (@(posedge CLK) disable iff (!RST_N)
    (test_r == UPTP_TEST_SE0_NAK) |=> TEST_DRIVE.se0_nak)
    else $error("SE0 NAK test mode not driven");

  a_test_packet: assert property (@(posedge CLK) disable iff (!RST_N)
    (test_r == UPTP_TEST_PACKET) |=> TEST_DRIVE.packet)
    else $error("packet test mode not driven");

  a_test_force: assert property (@(posedge CLK) disable iff (!RST_N)
    (test_r == UPTP_TEST_FORCE_EN) |=> TEST_DRIVE.force_en)
    else $error("force enable test mode not driven");

  a_test_onehot: assert property (@(posedge CLK) disable iff (!RST_N)
    $onehot0(TEST_DRIVE))
    else $error("more than one test mode driven");

  a_test_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    !WR.test_we |=> $stable(test_r))
    else $error("test select changed without write");

  a_test_write: assert property (@(posedge CLK) disable iff (!RST_N)
    WR.test_we |=> test_r == TEST_W'($past(WR.test_data)))
    else $error("test select write lost");

  // checks: ownership against the configure flag and software
  a_owner_cf_low: assert property (@(posedge CLK) disable iff (!RST_N)
    !CONFIGURE_FLAG |=> owner_r)
    else $error("ownership not forced while flag low");

  a_owner_cf_rise: assert property (@(posedge CLK) disable iff (!RST_N)
    (CONFIGURE_FLAG && !cf_prev_r) |=> !owner_r)
    else $error("ownership not cleared on flag rise");

  a_owner_handoff: assert property (@(posedge CLK) disable iff (!RST_N)
    owner_r |=> COMPANION_OWNS)
    else $error("companion not given port");

  a_owner_release: assert property (@(posedge CLK) disable iff (!RST_N)
    !owner_r |=> !COMPANION_OWNS)
    else $error("companion kept port after ownership cleared");

  a_owner_write: assert property (@(posedge CLK) disable iff (!RST_N)
    (CONFIGURE_FLAG && cf_prev_r && WR.owner_we) |=> owner_r == $past(WR.owner_data))
    else $error("ownership write lost");

  a_owner_keep: assert property (@(posedge CLK) disable iff (!RST_N)
    (CONFIGURE_FLAG && cf_prev_r && !WR.owner_we) |=> $stable(owner_r))
    else $error("ownership changed without cause");

  a_owner_flag_out: assert property (@(posedge CLK) disable iff (!RST_N)
    !CONFIGURE_FLAG |=> ##1 COMPANION_OWNS)
    else $error("companion not given port while flag low");

  // checks: power switching and status gating
  a_power_nocap: assert property (@(posedge CLK) disable iff (!RST_N)
    !POWER_SWITCH_CAP |=> power_r ##1 POWER_SWITCH_ON)
    else $error("power not on without switches");

  a_power_oc: assert property (@(posedge CLK) disable iff (!RST_N)
    (POWER_SWITCH_CAP && oc_sync_r && power_r) |=> !power_r)
    else $error("overcurrent did not cut power");

  a_power_write: assert property (@(posedge CLK) disable iff (!RST_N)
    (POWER_SWITCH_CAP && WR.power_we && !(oc_sync_r && power_r))
      |=> power_r == $past(WR.power_data))
    else $error("power write lost");

  a_power_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    (POWER_SWITCH_CAP && !WR.power_we && !(oc_sync_r && power_r)) |=> $stable(power_r))
    else $error("power bit changed without cause");

  a_power_switch: assert property (@(posedge CLK) disable iff (!RST_N)
    POWER_SWITCH_ON == $past(power_r))
    else $error("switch does not follow power bit");

  a_status_gate: assert property (@(posedge CLK) disable iff (!RST_N)
    !power_r |=> !STATUS_CHANGE_OUT)
    else $error("status change from unpowered port");

  a_status_pass: assert property (@(posedge CLK) disable iff (!RST_N)
    (power_r && STATUS_CHANGE_IN) |=> STATUS_CHANGE_OUT)
    else $error("status change lost on powered port");

  // checks: line-state sampling and its validity window
  a_line_sample: assert property (@(posedge CLK) disable iff (!RST_N)
    power_r |=> LINE_STATE_FIELD == $past(ls_sync_r))
    else $error("line state not sampled");

  a_line_unpowered: assert property (@(posedge CLK) disable iff (!RST_N)
    !power_r |=> LINE_STATE_FIELD == UPTP_LS_SE0)
    else $error("line state shown on unpowered port");

  a_valid_unpowered: assert property (@(posedge CLK) disable iff (!RST_N)
    !power_r |=> !LS_VALID)
    else $error("line state valid on unpowered port");

  a_valid_window: assert property (@(posedge CLK) disable iff (!RST_N)
    (power_r && !PORT_ENABLED && CONNECT_STATUS) |=> LS_VALID)
    else $error("line state valid flag missing");

  // covers for the main scenarios
  c_cf_rise: cover property (@(posedge CLK) disable iff (!RST_N)
    CONFIGURE_FLAG && !cf_prev_r);
  c_oc_cut: cover property (@(posedge CLK) disable iff (!RST_N)
    POWER_SWITCH_CAP && oc_sync_r && power_r);
  c_ls_k: cover property (@(posedge CLK) disable iff (!RST_N)
    LS_VALID && LINE_STATE_FIELD == UPTP_LS_K);
  c_test_pkt: cover property (@(posedge CLK) disable iff (!RST_N)
    TEST_DRIVE.packet);
  c_owner_write: cover property (@(posedge CLK) disable iff (!RST_N)
    CONFIGURE_FLAG && cf_prev_r && WR.owner_we && WR.owner_data);

endmodule

//--- test/uptp_usb_dev.sv
// behavioural usb device on the downstream port, drives the data lines
`timescale 1ns/1ps
module uptp_usb_dev (
  // device condition
  input wire logic ATTACHED,
  input wire logic LOW_SPEED,
  // data lines
  output logic POS_LINE,
  output logic NEG_LINE
);
  // idle levels: low speed pulls the negative line up, full speed the positive one
  always_comb begin
    if (!ATTACHED) begin
      {POS_LINE, NEG_LINE} = 2'b00; // host pull-downs win when nothing is attached
    end else begin
      {POS_LINE, NEG_LINE} = LOW_SPEED ? 2'b01 : 2'b10;
    end
  end
endmodule

//--- test/usb_port_owner_power_linestate_test.sv
// self-checking bench for the port owner, power and line-state block
`timescale 1ns/1ps
module usb_port_owner_power_linestate_test;
  import uptp_pkg::*;
  logic CLK, RST_N, cf, cap, oc, pe, cc, sci, att, lsp, dp, dm;
  uptp_wr_t wr;
  logic [3:0] tsel;
  logic own, pwr, sw_on, sco, lsv, owns;
  logic [1:0] ls;
  uptp_test_t tdrv;
  int fail_count = 0;
  int n_checks = 0;
  uptp_usb_dev dev (.ATTACHED(att), .LOW_SPEED(lsp), .POS_LINE(dp), .NEG_LINE(dm));
  uptp_port dut (.CLK(CLK), .RST_N(RST_N), .WR(wr), .CONFIGURE_FLAG(cf),
    .POWER_SWITCH_CAP(cap), .OVERCURRENT(oc), .PORT_ENABLED(pe), .CONNECT_STATUS(cc),
    .STATUS_CHANGE_IN(sci), .POSITIVE_DATA_LINE(dp), .NEGATIVE_DATA_LINE(dm),
    .PORT_TEST_SELECT(tsel), .COMPANION_OWNERSHIP_BIT(own), .PORT_POWER_BIT(pwr),
    .LINE_STATE_FIELD(ls), .TEST_DRIVE(tdrv), .COMPANION_OWNS(owns),
    .POWER_SWITCH_ON(sw_on), .STATUS_CHANGE_OUT(sco), .LS_VALID(lsv));
  // 200 MHz clock
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one-cycle write strobe; returns just after the taking edge
  task automatic wrs(input uptp_wr_t w);
    @(posedge CLK) wr <= w;
    @(posedge CLK) wr <= '0;
    #1;
  endtask
  task automatic edge1;
    @(posedge CLK);
    #1;
  endtask
  task automatic t_test;
    for (int c = 0; c < 6; c++) begin // reserved codes 6..15 never written
      wrs('{test_we: 1'b1, test_data: 4'(c), default: '0});
      chk(8'(tsel), 8'(c));
      edge1();
      chk(8'(tdrv), 8'((c inside {[1:5]}) ? 5'b10000 >> (c - 1) : 5'b0));
    end
  endtask
  task automatic t_owner;
    wrs('{owner_we: 1'b1, owner_data: 1'b0, default: '0});
    chk(8'(own), 8'h01);
    @(posedge CLK) cf <= 1'b1;
    edge1();
    chk(8'(own), 8'h00);
    edge1();
    chk(8'(owns), 8'h00);
    wrs('{owner_we: 1'b1, owner_data: 1'b1, default: '0}); // hand-off for a slow device
    edge1();
    chk(8'({own, owns}), 8'h03);
  endtask
  task automatic t_power;
    int i;
    logic [1:0] exp_ls;
    wrs('{power_we: 1'b1, power_data: 1'b1, default: '0});
    chk(8'(pwr), 8'h01);
    @(posedge CLK) sci <= 1'b1;
    edge1();
    chk(8'({sw_on, sco}), 8'h03);
    for (int s = 0; s < 3; s++) begin
      // s=0 nothing attached, s=1 low speed s=2 full speed
      @(posedge CLK) {att, lsp} <= (s == 0) ? 2'b00 : ((s == 1) ? 2'b11 : 2'b10);
      exp_ls = (s == 0) ? UPTP_LS_SE0 : ((s == 1) ? UPTP_LS_K : UPTP_LS_J);
      repeat (4) edge1();
      chk(8'({ls, lsv}), 8'({exp_ls, 1'b1}));
    end
    // port enabled: line state no longer meaningful for software
    @(posedge CLK) pe <= 1'b1;
    repeat (2) edge1();
    chk(8'(lsv), 8'h00);
    @(posedge CLK) pe <= 1'b0;
    @(posedge CLK) oc <= 1'b1;
    for (i = 0; i < 8 && pwr !== 1'b0; i++) edge1(); // cut expected within 8 edges
    if (i == 8) begin
      fail_count++;
      report_and_stop();
    end
    repeat (4) edge1();
    chk(8'({sco, sw_on, ls}), 8'h00);
    @(posedge CLK) oc <= 1'b0;
    @(posedge CLK) cap <= 1'b0;
    edge1();
    edge1();
    chk(8'(pwr), 8'h01);
  endtask
  initial begin
    {RST_N, cf, oc, pe, sci, att, lsp} = '0;
    {cap, cc} = 2'b11;
    wr = '0; // write word has no reserved bits; idle strobes stay low
    repeat (2) @(posedge CLK);
    @(posedge CLK) RST_N <= 1'b1; // reset seen low at three edges
    #1;
    chk(8'({tsel, own, pwr, owns, sw_on}), 8'h0a);
    t_test();
    t_owner();
    t_power();
    wrs('{owner_we: 1'b1, owner_data: 1'b0, default: '0});
    chk(8'(own), 8'h00);
    @(posedge CLK) cf <= 1'b0;
    edge1();
    chk(8'(own), 8'h01);
    report_and_stop();
  end
endmodule
